/* timer_unit.sv */
// three timer/counters with apb register access
//
// Contract
// - window timer mode counts internal clock; compare match flags, clears, continues.
// - window counter mode counts selected pin edge; same match behaviour.
// - window mode counts internal clock gated by pin; match flags and clears.
// - writing low compare byte blocks matching until high byte is written.
// - capture timer mode counts internal clock; match with data a clears.
// - snapshot bit copies count into data b outside capture mode, then self-clears.
// - capture counter mode counts one chosen pin edge, never both.
// - capture mode leading edge stores count in data a, clears, flags.
// - capture mode trailing edge stores count in data b, no clear.
// - overflow before edge loads all ones into data a and flags.
// - after capture or overflow, detection halts until data a is read.
// - divider timer mode counts internal clock; match flags and clears.
// - divider counter mode counts rising pin edges; same match behaviour.
// - divider output mode toggles flop, clears on match; pin is inverted flop.
// - divider output mode flags on every match toggle of the output pin.
// - divider flop is software settable and reset to zero.
// - pwm mode toggles on match, toggles and clears on overflow.
// - pwm mode flags once per counter overflow.
// - pwm compare is double buffered, taken at period end or when the start bit is set.
// - setting divider start bit loads compare into the active stage.
`timescale 1ns/100ps
module timer_unit
  import timer_unit_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        srst,
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        window_timer_input_pin,
  input  wire logic        capture_timer_input_pin,
  input  wire logic        divider_timer_input_pin,
  output logic             divider_output_pin_n,
  output logic             timer_irq
);

  unit_state_t s_q;
  unit_state_t s_d;

  pin_edge_t   win_pin;
  pin_edge_t   cap_pin;
  pin_edge_t   div_pin;

  logic        apb_wr;
  logic        apb_rd;
  logic        addr_hit;
  logic [7:0]  rd_byte;
  logic        win_tick;
  logic        win_evt;
  logic        win_set;
  logic [15:0] win_cmp;
  logic        cap_tick;
  logic        cap_lead;
  logic        cap_trail;
  logic        cap_evt;
  logic        cap_set;
  logic        cap_snap_take;
  logic        div_tick;
  logic        div_evt;
  logic        div_set;
  logic        pwm_wrap;
  div_mode_t   div_mode;

  // tick every 2**sel system clocks from the free-running prescaler
  function automatic logic tick_of(input logic [15:0] presc,
                                   input logic [2:0]  sel);
    logic [15:0] m;
    m = (16'h0001 << sel) - 16'h0001;
    return (presc & m) == m;
  endfunction : tick_of

  pin_sync_edge #(.RESET_LEVEL(1'b0)) u_win_sync (
    .clk_sys (clk_sys),
    .srst    (srst),
    .pin     (window_timer_input_pin),
    .edges   (win_pin)
  );

  pin_sync_edge #(.RESET_LEVEL(1'b0)) u_cap_sync (
    .clk_sys (clk_sys),
    .srst    (srst),
    .pin     (capture_timer_input_pin),
    .edges   (cap_pin)
  );

  pin_sync_edge #(.RESET_LEVEL(1'b0)) u_div_sync (
    .clk_sys (clk_sys),
    .srst    (srst),
    .pin     (divider_timer_input_pin),
    .edges   (div_pin)
  );

  // zero-wait slave; read data latched in the setup cycle
  assign apb_wr   = psel & penable & pwrite;
  assign apb_rd   = psel & penable & ~pwrite;
  assign pready   = 1'b1;
  assign pslverr  = psel & penable & ~addr_hit;

  always_comb begin
    addr_hit = 1'b1;
    rd_byte  = 8'h00;
    case (paddr)
      ADDR_CAP_CTRL:   rd_byte = s_q.cap_ctrl;
      ADDR_CAP_DATA_A: rd_byte = s_q.cap_data_a;
      ADDR_CAP_DATA_B: rd_byte = s_q.cap_data_b;
      ADDR_WIN_CTRL:   rd_byte = s_q.win_ctrl;
      ADDR_WIN_CMP_HI: rd_byte = s_q.win_cmp_hi;
      ADDR_WIN_CMP_LO: rd_byte = s_q.win_cmp_lo;
      ADDR_EDGE_CTRL:  rd_byte = s_q.edge_ctrl;
      ADDR_DIV_CTRL:   rd_byte = s_q.div_ctrl;
      ADDR_DIV_DATA:   rd_byte = s_q.div_data;
      ADDR_FLAGS:      rd_byte = s_q.flags;
      ADDR_MASK:       rd_byte = s_q.mask;
      default:         addr_hit = 1'b0;
    endcase
  end

  always_comb begin
    s_d           = s_q;
    s_d.presc     = s_q.presc + 16'h0001;
    win_set       = 1'b0;
    cap_set       = 1'b0;
    div_set       = 1'b0;
    cap_evt       = 1'b0;
    div_evt       = 1'b0;
    pwm_wrap      = 1'b0;
    div_mode      = div_mode_t'(s_q.div_ctrl[1:0]);

    // window timer
    win_cmp  = {s_q.win_cmp_hi, s_q.win_cmp_lo};
    win_tick = tick_of(s_q.presc, s_q.win_ctrl[2:0]);
    if (s_q.win_ctrl[WIN_MODE_BIT]) begin
      win_evt = win_tick & win_pin.level;
    end else if (s_q.win_ctrl[2:0] == WIN_EXT_SEL) begin
      win_evt = s_q.edge_ctrl[EDGE_WIN_BIT] ? win_pin.fall
                                            : win_pin.rise;
    end else begin
      win_evt = win_tick;
    end
    win_evt = win_evt & s_q.win_ctrl[WIN_START_BIT];
    if (win_evt) begin
      if (!s_q.win_inhibit && s_q.win_cnt == win_cmp) begin
        s_d.win_cnt = RST_WORD;
        win_set     = 1'b1;
      end else begin
        s_d.win_cnt = s_q.win_cnt + 16'h0001;
      end
    end

    // capture timer; a read of data a re-arms before new edges are seen
    if (apb_rd && paddr == ADDR_CAP_DATA_A) begin
      s_d.cap_hold = 1'b0;
    end
    cap_tick  = tick_of(s_q.presc, {1'b0, s_q.cap_ctrl[5:4]});
    cap_lead  = s_q.edge_ctrl[EDGE_CAP_BIT] ? cap_pin.fall
                                            : cap_pin.rise;
    cap_trail = s_q.edge_ctrl[EDGE_CAP_BIT] ? cap_pin.rise
                                            : cap_pin.fall;
    cap_snap_take = s_q.cap_ctrl[CAP_SNAP_BIT] & ~s_q.cap_ctrl[CAP_MODE_BIT];
    if (cap_snap_take) begin
      s_d.cap_data_b = s_q.cap_cnt;
    end
    s_d.cap_ctrl[CAP_SNAP_BIT] = 1'b0;
    if (s_q.cap_ctrl[CAP_START_BIT]) begin
      if (s_q.cap_ctrl[CAP_MODE_BIT]) begin
        if (cap_tick) begin
          s_d.cap_cnt = s_q.cap_cnt + 8'h01;
        end
        if (s_d.cap_hold == 1'b0) begin
          if (cap_lead) begin
            s_d.cap_data_a = s_q.cap_cnt;
            s_d.cap_cnt    = RST_BYTE;
            s_d.cap_hold   = 1'b1;
            cap_set        = 1'b1;
          end else if (cap_tick && s_q.cap_cnt == CNT_MAX8) begin
            s_d.cap_data_a = CAP_OVF_VALUE;
            s_d.cap_hold   = 1'b1;
            cap_set        = 1'b1;
          end else if (cap_trail) begin
            s_d.cap_data_b = s_q.cap_cnt;
          end
        end
      end else begin
        cap_evt = (s_q.cap_ctrl[5:4] == CAP_EXT_SEL) ? cap_lead
                                                     : cap_tick;
        if (cap_evt) begin
          if (s_q.cap_cnt == s_q.cap_data_a) begin
            s_d.cap_cnt = RST_BYTE;
            cap_set     = 1'b1;
          end else begin
            s_d.cap_cnt = s_q.cap_cnt + 8'h01;
          end
        end
      end
    end

    // divider timer
    div_tick = tick_of(s_q.presc, s_q.div_ctrl[4:2]);
    if (s_q.div_ctrl[DIV_START_BIT]) begin
      case (div_mode)
        DIV_PDO: begin
          if (div_tick) begin
            if (s_q.div_cnt == s_q.div_data) begin
              s_d.div_ff  = ~s_q.div_ff;
              s_d.div_cnt = RST_BYTE;
              div_set     = 1'b1;
            end else begin
              s_d.div_cnt = s_q.div_cnt + 8'h01;
            end
          end
        end
        DIV_PWM: begin
          if (div_tick) begin
            // a compare of all ones toggles twice: a flat output
            s_d.div_ff = s_q.div_ff ^ (s_q.div_cnt == s_q.div_active)
                                   ^ (s_q.div_cnt == CNT_MAX8);
            if (s_q.div_cnt == CNT_MAX8) begin
              pwm_wrap       = 1'b1;
              s_d.div_cnt    = RST_BYTE;
              s_d.div_active = s_q.div_data;
              div_set        = 1'b1;
            end else begin
              s_d.div_cnt = s_q.div_cnt + 8'h01;
            end
          end
        end
        default: begin
          div_evt = (s_q.div_ctrl[4:2] == DIV_EXT_SEL) ? div_pin.rise
                                                       : div_tick;
          if (div_evt) begin
            if (s_q.div_cnt == s_q.div_data) begin
              s_d.div_cnt = RST_BYTE;
              div_set     = 1'b1;
            end else begin
              s_d.div_cnt = s_q.div_cnt + 8'h01;
            end
          end
        end
      endcase
    end

    // software writes; hardware flag sets are merged after them
    if (apb_wr) begin
      case (paddr)
        ADDR_CAP_CTRL:   s_d.cap_ctrl   = pwdata[7:0] & CAP_CTRL_MASK;
        ADDR_CAP_DATA_A: s_d.cap_data_a = pwdata[7:0];
        ADDR_CAP_DATA_B: s_d.cap_data_b = pwdata[7:0];
        ADDR_WIN_CTRL:   s_d.win_ctrl   = pwdata[7:0] & WIN_CTRL_MASK;
        ADDR_WIN_CMP_HI: begin
          s_d.win_cmp_hi  = pwdata[7:0];
          s_d.win_inhibit = 1'b0;
        end
        ADDR_WIN_CMP_LO: begin
          s_d.win_cmp_lo  = pwdata[7:0];
          s_d.win_inhibit = 1'b1;
        end
        ADDR_EDGE_CTRL:  s_d.edge_ctrl  = pwdata[7:0] & EDGE_CTRL_MASK;
        ADDR_DIV_CTRL: begin
          s_d.div_ctrl = pwdata[7:0];
          if (pwdata[DIV_FF_CTL_BIT]) begin
            s_d.div_ff = pwdata[DIV_FF_VAL_BIT];
          end
          if (pwdata[DIV_START_BIT] && !s_q.div_ctrl[DIV_START_BIT]) begin
            s_d.div_active = s_q.div_data;
          end
        end
        ADDR_DIV_DATA:   s_d.div_data   = pwdata[7:0];
        ADDR_FLAGS:      s_d.flags      = pwdata[7:0] & FLAG_MASK;
        ADDR_MASK:       s_d.mask       = pwdata[7:0] & FLAG_MASK;
        default:         s_d.flags      = s_d.flags;
      endcase
    end

    // set wins over a clearing write in the same cycle
    s_d.flags[FLAG_WIN_BIT] = s_d.flags[FLAG_WIN_BIT] | win_set;
    s_d.flags[FLAG_CAP_BIT] = s_d.flags[FLAG_CAP_BIT] | cap_set;
    s_d.flags[FLAG_DIV_BIT] = s_d.flags[FLAG_DIV_BIT] | div_set;
    s_d.irq       = |(s_d.flags & s_d.mask);
    s_d.div_out_n = ~s_d.div_ff;

    if (psel && !penable) begin
      s_d.prdata = {24'h000000, rd_byte};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      s_q           <= '0;
      s_q.div_out_n <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata               = s_q.prdata;
  assign divider_output_pin_n = s_q.div_out_n;
  assign timer_irq            = s_q.irq;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  sequence pwm_wrap_s;
    s_q.div_ctrl[DIV_START_BIT] && div_mode == DIV_PWM && div_tick
      && s_q.div_cnt == CNT_MAX8;
  endsequence

  sequence wrap_done_s;
    s_q.div_cnt == 8'h00 && s_q.flags[FLAG_DIV_BIT]
      && s_q.div_active == $past(s_q.div_data);
  endsequence

  sequence cap_lead_s;
    s_q.cap_ctrl[CAP_START_BIT] && s_q.cap_ctrl[CAP_MODE_BIT]
      && s_d.cap_hold == 1'b0 && cap_lead && !apb_wr;
  endsequence

  win_match_a: assert property (
    win_evt && !s_q.win_inhibit && s_q.win_cnt == win_cmp
      |=> s_q.win_cnt == 16'h0000 && s_q.flags[FLAG_WIN_BIT])
    else $error("window match did not clear and flag");

  win_inhibit_a: assert property (
    win_evt && s_q.win_inhibit
      |=> s_q.win_cnt == $past(s_q.win_cnt) + 16'h0001)
    else $error("window matched while compare inhibited");

  cap_snap_a: assert property (
    cap_snap_take && !apb_wr
      |=> s_q.cap_data_b == $past(s_q.cap_cnt)
        && !s_q.cap_ctrl[CAP_SNAP_BIT])
    else $error("snapshot not copied or bit not cleared");

  cap_edge_a: assert property (
    cap_lead_s |=> s_q.cap_data_a == $past(s_q.cap_cnt)
      && s_q.cap_cnt == 8'h00 && s_q.cap_hold
      && s_q.flags[FLAG_CAP_BIT])
    else $error("leading edge capture wrong");

  cap_ovf_a: assert property (
    s_q.cap_ctrl[CAP_START_BIT] && s_q.cap_ctrl[CAP_MODE_BIT]
      && s_d.cap_hold == 1'b0 && !cap_lead && cap_tick
      && s_q.cap_cnt == CNT_MAX8 && !apb_wr
      |=> s_q.cap_data_a == 8'hFF && s_q.flags[FLAG_CAP_BIT])
    else $error("overflow did not load all ones");

  cap_hold_a: assert property (
    s_q.cap_hold && !apb_rd && !apb_wr
      |=> $stable(s_q.cap_data_a) && s_q.cap_hold)
    else $error("capture not halted before data read");

  div_pdo_a: assert property (
    s_q.div_ctrl[DIV_START_BIT] && div_mode == DIV_PDO && div_tick
      && s_q.div_cnt == s_q.div_data && !apb_wr
      |=> divider_output_pin_n != $past(divider_output_pin_n)
        && s_q.flags[FLAG_DIV_BIT])
    else $error("divider output did not toggle on match");

  pwm_wrap_a: assert property (
    pwm_wrap_s |=> wrap_done_s)
    else $error("pwm overflow did not clear, flag and reload");

  pwm_hold_a: assert property (
    div_mode == DIV_PWM && !pwm_wrap && !apb_wr
      |=> $stable(s_q.div_active))
    else $error("pwm compare changed mid period");

  irq_gate_a: assert property (
    s_q.flags[FLAG_CAP_BIT] && s_q.mask[FLAG_CAP_BIT] && !apb_wr
      |=> timer_irq && s_q.flags[FLAG_CAP_BIT])
    else $error("masked-in flag did not hold interrupt");

  stop_hold_a: assert property (
    !s_q.div_ctrl[DIV_START_BIT] && !apb_wr |=> $stable(s_q.div_cnt))
    else $error("divider counted while stopped");

endmodule : timer_unit

/* timer_unit_pkg.sv */
// constants, enumerations and state carriers for the three-timer unit
package timer_unit_pkg;

  // register bank bases; byte address = base + 4 * index
  localparam logic [11:0] BANK0_BASE      = 12'h000;
  localparam logic [11:0] BANK1_BASE      = 12'h040;
  localparam logic [11:0] SFR_BASE        = 12'h080;

  localparam logic [11:0] IDX_CAP_CTRL    = 12'h005;
  localparam logic [11:0] IDX_CAP_DATA_A  = 12'h006;
  localparam logic [11:0] IDX_CAP_DATA_B  = 12'h007;
  localparam logic [11:0] IDX_WIN_CTRL    = 12'h008;
  localparam logic [11:0] IDX_WIN_CMP_HI  = 12'h009;
  localparam logic [11:0] IDX_WIN_CMP_LO  = 12'h00A;
  localparam logic [11:0] IDX_EDGE_CTRL   = 12'h00B;
  localparam logic [11:0] IDX_DIV_CTRL    = 12'h00B;
  localparam logic [11:0] IDX_DIV_DATA    = 12'h00C;
  localparam logic [11:0] IDX_FLAGS       = 12'h00E;
  localparam logic [11:0] IDX_MASK        = 12'h00E;

  localparam logic [11:0] ADDR_CAP_CTRL   = BANK1_BASE + (IDX_CAP_CTRL << 2);
  localparam logic [11:0] ADDR_CAP_DATA_A = BANK1_BASE + (IDX_CAP_DATA_A << 2);
  localparam logic [11:0] ADDR_CAP_DATA_B = BANK1_BASE + (IDX_CAP_DATA_B << 2);
  localparam logic [11:0] ADDR_WIN_CTRL   = BANK1_BASE + (IDX_WIN_CTRL << 2);
  localparam logic [11:0] ADDR_WIN_CMP_HI = BANK1_BASE + (IDX_WIN_CMP_HI << 2);
  localparam logic [11:0] ADDR_WIN_CMP_LO = BANK1_BASE + (IDX_WIN_CMP_LO << 2);
  localparam logic [11:0] ADDR_EDGE_CTRL  = SFR_BASE + (IDX_EDGE_CTRL << 2);
  localparam logic [11:0] ADDR_DIV_CTRL   = BANK0_BASE + (IDX_DIV_CTRL << 2);
  localparam logic [11:0] ADDR_DIV_DATA   = BANK0_BASE + (IDX_DIV_DATA << 2);
  localparam logic [11:0] ADDR_FLAGS      = BANK0_BASE + (IDX_FLAGS << 2);
  localparam logic [11:0] ADDR_MASK       = SFR_BASE + (IDX_MASK << 2);

  // field positions
  localparam int unsigned WIN_MODE_BIT    = 4;
  localparam int unsigned WIN_START_BIT   = 3;
  localparam int unsigned CAP_SNAP_BIT    = 7;
  localparam int unsigned CAP_START_BIT   = 6;
  localparam int unsigned CAP_MODE_BIT    = 3;
  localparam int unsigned DIV_FF_CTL_BIT  = 7;
  localparam int unsigned DIV_FF_VAL_BIT  = 6;
  localparam int unsigned DIV_START_BIT   = 5;
  localparam int unsigned EDGE_WIN_BIT    = 0;
  localparam int unsigned EDGE_CAP_BIT    = 3;
  localparam int unsigned FLAG_WIN_BIT    = 6;
  localparam int unsigned FLAG_DIV_BIT    = 2;
  localparam int unsigned FLAG_CAP_BIT    = 0;

  // writable bits; the rest read as zero
  localparam logic [7:0]  WIN_CTRL_MASK   = 8'h1F;
  localparam logic [7:0]  CAP_CTRL_MASK   = 8'hF8;
  localparam logic [7:0]  EDGE_CTRL_MASK  = 8'hDB;
  localparam logic [7:0]  FLAG_MASK       = 8'h45;

  localparam logic [7:0]  RST_BYTE        = 8'h00;
  localparam logic [15:0] RST_WORD        = 16'h0000;
  localparam logic [7:0]  CAP_OVF_VALUE   = 8'hFF;
  localparam logic [7:0]  CNT_MAX8        = 8'hFF;

  // clock-select codes that pick the external pin
  localparam logic [2:0]  WIN_EXT_SEL     = 3'h7;
  localparam logic [1:0]  CAP_EXT_SEL     = 2'h3;
  localparam logic [2:0]  DIV_EXT_SEL     = 3'h7;

  typedef enum logic [1:0] {
    DIV_TIMER = 2'b00,
    DIV_PDO   = 2'b01,
    DIV_PWM   = 2'b10,
    DIV_RSVD  = 2'b11
  } div_mode_t;

  typedef struct packed {
    logic level;
    logic rise;
    logic fall;
  } pin_edge_t;

  typedef struct packed {
    logic meta;
    logic level;
    logic prev;
  } pin_sync_t;

  typedef struct packed {
    logic [15:0] presc;
    logic [7:0]  win_ctrl;
    logic [7:0]  win_cmp_hi;
    logic [7:0]  win_cmp_lo;
    logic        win_inhibit;
    logic [15:0] win_cnt;
    logic [7:0]  cap_ctrl;
    logic [7:0]  cap_data_a;
    logic [7:0]  cap_data_b;
    logic [7:0]  cap_cnt;
    logic        cap_hold;
    logic [7:0]  edge_ctrl;
    logic [7:0]  div_ctrl;
    logic [7:0]  div_data;
    logic [7:0]  div_active;
    logic [7:0]  div_cnt;
    logic        div_ff;
    logic        div_out_n;
    logic [7:0]  flags;
    logic [7:0]  mask;
    logic [31:0] prdata;
    logic        irq;
  } unit_state_t;

endpackage : timer_unit_pkg

/* pin_sync_edge.sv */
// two-flop pin synchroniser with edge pulses
`timescale 1ns/100ps
module pin_sync_edge
  import timer_unit_pkg::*;
#(
  parameter logic RESET_LEVEL = 1'b0
) (
  input  wire logic clk_sys,
  input  wire logic srst,
  input  wire logic pin,
  output pin_edge_t edges
);

  pin_sync_t s_q;
  pin_sync_t s_d;

  // meta is read by level only
  always_comb begin
    s_d       = s_q;
    s_d.meta  = pin;
    s_d.level = s_q.meta;
    s_d.prev  = s_q.level;
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      s_q <= {RESET_LEVEL, RESET_LEVEL, RESET_LEVEL};
    end else begin
      s_q <= s_d;
    end
  end

  assign edges.level = s_q.level;
  assign edges.rise  = s_q.level & ~s_q.prev;
  assign edges.fall  = ~s_q.level & s_q.prev;

endmodule : pin_sync_edge

/* pin_source.sv */
// pulse source standing in for the outside count and gate pins
`timescale 1ns/100ps
module pin_source (
  input  wire logic       clk_sys,
  input  wire logic [2:0] pulse_req,
  output logic      [2:0] pins
);
  logic [2:0][2:0] cnt_q;

  initial begin
    pins = 3'h0;
    cnt_q = '0;
  end

  // 3 cycles high, 4 low: slower than any internal tick it meets
  always @(posedge clk_sys) begin
    for (int i = 0; i < 3; i++) begin
      if (pulse_req[i] && cnt_q[i] == 3'h0)
        cnt_q[i] <= 3'h6;
      else if (cnt_q[i] != 3'h0)
        cnt_q[i] <= cnt_q[i] - 3'h1;
      pins[i] <= (cnt_q[i] > 3'h3);
    end
  end
endmodule : pin_source

/* tb.sv */
// self-checking bench for the three-timer unit
`timescale 1ns/100ps
module tb;
  import timer_unit_pkg::*;
  logic        clk_sys, srst, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr, out_n, irq, lo;
  logic [2:0]  req, pins;
  logic [7:0]  exp_q[$];
  logic [7:0]  dv;
  int          n_fail, checks, seed, tog;

  timer_unit DUT (
    .clk_sys(clk_sys), .srst(srst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .window_timer_input_pin(pins[0]), .capture_timer_input_pin(pins[1]),
    .divider_timer_input_pin(pins[2]), .divider_output_pin_n(out_n),
    .timer_irq(irq));

  pin_source partner (.clk_sys(clk_sys), .pulse_req(req), .pins(pins));

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] s);
    checks++;
    if (s !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  // read data is judged by the monitor below, in order of issue
  always @(posedge clk_sys) begin
    if (psel && penable && pready && !pwrite && exp_q.size() > 0)
      chk("prdata", exp_q.pop_front(), prdata[7:0]);
  end

  task automatic apb(input logic [11:0] a, input logic w,
                     input logic [7:0] d);
    if (!w)
      exp_q.push_back(d);
    paddr <= a;
    pwrite <= w;
    pwdata <= {24'h0, d};
    psel <= 1'b1;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    // only the watchdog ends a wait for the slave
    while (pready !== 1'b1)
      @(posedge clk_sys);
    chk("pslverr", {7'h0, a == 12'hFFC}, {7'h0, pslverr});
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask : apb

  task automatic pulse(input int p, input int k);
    repeat (k) begin
      req[p] <= 1'b1;
      @(posedge clk_sys);
      req[p] <= 1'b0;
      repeat (10) @(posedge clk_sys);
    end
  endtask : pulse

  task automatic count_tog(input int k);
    tog = 0;
    repeat (k) begin
      lo = out_n;
      @(posedge clk_sys);
      if (out_n !== lo)
        tog++;
    end
  endtask : count_tog

  task automatic print_verdict();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : print_verdict

  initial begin
    repeat (20000) @(posedge clk_sys);
    n_fail++;
    print_verdict();
  end

  initial begin
    seed = 32'hb3afd562;
    {srst, psel, penable, pwrite, paddr, pwdata, req} = '0;
    srst = 1'b1;
    repeat (5) @(posedge clk_sys);
    srst <= 1'b0;
    @(posedge clk_sys);
    chk("pin_n", 8'h01, {7'h0, out_n});
    apb(ADDR_FLAGS, 1'b0, 8'h00);
    apb(12'hFFC, 1'b0, 8'h00);
    // divider on its pin: period of D+1 rising edges
    apb(ADDR_DIV_DATA, 1'b1, 8'h02);
    apb(ADDR_DIV_CTRL, 1'b1, 8'h3C);
    pulse(2, 2);
    apb(ADDR_FLAGS, 1'b0, 8'h00);
    pulse(2, 1);
    apb(ADDR_FLAGS, 1'b0, 8'h04);
    apb(ADDR_FLAGS, 1'b1, 8'h00);
    $display("test divider counter done");
    // divider timer with a random match value, then mask and stop
    dv = 8'h02 + 8'($unsigned($random(seed)) % 8);
    apb(ADDR_DIV_DATA, 1'b1, dv);
    apb(ADDR_DIV_CTRL, 1'b1, 8'h20);
    repeat (2 * dv + 6) @(posedge clk_sys);
    apb(ADDR_FLAGS, 1'b0, 8'h04);
    chk("timer_irq", 8'h00, {7'h0, irq});
    apb(ADDR_MASK, 1'b1, 8'h04);
    repeat (2) @(posedge clk_sys);
    chk("timer_irq", 8'h01, {7'h0, irq});
    apb(ADDR_DIV_CTRL, 1'b1, 8'h00);
    apb(ADDR_FLAGS, 1'b1, 8'h00);
    repeat (3 * dv) @(posedge clk_sys);
    apb(ADDR_FLAGS, 1'b0, 8'h00);
    chk("timer_irq", 8'h00, {7'h0, irq});
    $display("test divider timer done");
    // window timer counting rising pin edges against 16-bit compare
    apb(ADDR_WIN_CMP_LO, 1'b1, 8'h02);
    apb(ADDR_WIN_CMP_HI, 1'b1, 8'h00);
    apb(ADDR_EDGE_CTRL, 1'b1, 8'h00);
    apb(ADDR_WIN_CTRL, 1'b1, 8'h0F);
    pulse(0, 2);
    apb(ADDR_FLAGS, 1'b0, 8'h00);
    pulse(0, 1);
    apb(ADDR_FLAGS, 1'b0, 8'h40);
    apb(ADDR_FLAGS, 1'b1, 8'h00);
    // low byte alone: a zero compare would match every edge
    apb(ADDR_WIN_CMP_LO, 1'b1, 8'h00);
    pulse(0, 1);
    apb(ADDR_FLAGS, 1'b0, 8'h00);
    apb(ADDR_WIN_CTRL, 1'b1, 8'h00);
    // window mode: count held at 1, three ticks per gate pulse
    apb(ADDR_WIN_CMP_LO, 1'b1, 8'h05);
    apb(ADDR_WIN_CMP_HI, 1'b1, 8'h00);
    apb(ADDR_WIN_CTRL, 1'b1, 8'h18);
    pulse(0, 1);
    apb(ADDR_FLAGS, 1'b0, 8'h00);
    pulse(0, 1);
    apb(ADDR_FLAGS, 1'b0, 8'h40);
    apb(ADDR_WIN_CTRL, 1'b1, 8'h00);
    apb(ADDR_FLAGS, 1'b1, 8'h00);
    $display("test window done");
    // flop preset, then divider output every D+1 ticks
    apb(ADDR_DIV_CTRL, 1'b1, 8'hC0);
    repeat (2) @(posedge clk_sys);
    chk("pin_n", 8'h00, {7'h0, out_n});
    apb(ADDR_DIV_DATA, 1'b1, 8'h03);
    apb(ADDR_DIV_CTRL, 1'b1, 8'h21);
    // held count may sit above the match: let it wrap first
    repeat (270) @(posedge clk_sys);
    count_tog(40);
    chk("toggles", 8'h01, {7'h0, tog >= 9 && tog <= 11});
    apb(ADDR_FLAGS, 1'b0, 8'h04);
    $display("test divider output done");
    // pwm: two toggles per 256-tick period
    apb(ADDR_DIV_CTRL, 1'b1, 8'h00);
    apb(ADDR_DIV_DATA, 1'b1, 8'h40);
    apb(ADDR_FLAGS, 1'b1, 8'h00);
    apb(ADDR_DIV_CTRL, 1'b1, 8'h22);
    count_tog(512);
    chk("pwm_toggles", 8'h04, 8'(tog));
    apb(ADDR_DIV_DATA, 1'b1, 8'h80);
    apb(ADDR_FLAGS, 1'b1, 8'h00);
    repeat (300) @(posedge clk_sys);
    apb(ADDR_FLAGS, 1'b0, 8'h04);
    apb(ADDR_DIV_CTRL, 1'b1, 8'h00);
    apb(ADDR_FLAGS, 1'b1, 8'h00);
    $display("test pwm done");
    // capture mode: lead edge seen five ticks after start
    apb(ADDR_MASK, 1'b1, 8'h05);
    apb(ADDR_CAP_CTRL, 1'b1, 8'h48);
    pulse(1, 1);
    apb(ADDR_CAP_DATA_A, 1'b0, 8'h05);
    repeat (300) @(posedge clk_sys);
    apb(ADDR_CAP_DATA_A, 1'b0, 8'hFF);
    apb(ADDR_FLAGS, 1'b0, 8'h01);
    chk("timer_irq", 8'h01, {7'h0, irq});
    // timer mode with match at zero pins the count at zero
    apb(ADDR_CAP_CTRL, 1'b1, 8'h00);
    apb(ADDR_CAP_DATA_A, 1'b1, 8'h00);
    apb(ADDR_CAP_DATA_B, 1'b1, 8'h5A);
    apb(ADDR_CAP_CTRL, 1'b1, 8'h40);
    repeat (300) @(posedge clk_sys);
    apb(ADDR_CAP_CTRL, 1'b1, 8'hC0);
    apb(ADDR_CAP_DATA_B, 1'b0, 8'h00);
    apb(ADDR_CAP_CTRL, 1'b0, 8'h40);
    apb(ADDR_CAP_CTRL, 1'b1, 8'h00);
    $display("test capture done");
    print_verdict();
  end
endmodule : tb
